// ---- hdl/fcdma_pkg.sv ----
// Shared constants and types of the five-channel DMA controller.
// Assumes an AHB-Lite register bus and a simple one-unit memory port outside.
package fcdma_pkg;
    // Number of channels and of channels with external pins.
    localparam int NUM_CH = 5;
    localparam int NUM_EXT = 3;
    // Channel that may run fly-by transfers.
    localparam logic [2:0] FLY_CH = 3'h3;
    // Register map: channel n sits at n * 0x10, global control after them.
    localparam logic [1:0] REG_CTRL_A = 2'h0;
    localparam logic [1:0] REG_CTRL_B = 2'h1;
    localparam logic [1:0] REG_SRC = 2'h2;
    localparam logic [1:0] REG_DST = 2'h3;
    localparam logic [7:0] ADDR_GLOBAL = 8'h50;
    // Field positions of the channel control/status register A.
    localparam int A_CNT_LSB = 0;
    localparam int A_BLK_LSB = 16;
    localparam int A_TRIG_LSB = 20;
    localparam int A_EDGE = 22;
    localparam int A_SWREQ = 23;
    localparam int A_ENABLE = 24;
    localparam int A_RELOAD = 25;
    localparam int A_MODE_LSB = 26;
    localparam int A_SIZE_LSB = 28;
    // Field positions of the channel control/status register B.
    localparam int B_SSTEP_LSB = 0;
    localparam int B_SMODE_LSB = 8;
    localparam int B_DSTEP_LSB = 10;
    localparam int B_DMODE_LSB = 18;
    localparam int B_FLY_DIR = 20;
    localparam int B_FLY_EN = 21;
    localparam int B_DONE = 30;
    localparam int B_BUSY = 31;
    // Field positions of the global control register.
    localparam int G_ENABLE = 0;
    localparam int G_SWAP01 = 1;
    localparam int G_HALT = 2;
    // Trigger sources.
    localparam logic [1:0] TRIG_SW = 2'h0;
    localparam logic [1:0] TRIG_EXT = 2'h1;
    localparam logic [1:0] TRIG_PERIPH = 2'h2;
    // Transfer modes.
    localparam logic [1:0] MODE_DEMAND = 2'h0;
    localparam logic [1:0] MODE_BURST = 2'h1;
    localparam logic [1:0] MODE_STEP = 2'h2;
    localparam logic [1:0] MODE_BLOCK = 2'h3;
    // Address update modes.
    localparam logic [1:0] AMODE_FIXED = 2'h0;
    localparam logic [1:0] AMODE_INC = 2'h1;
    localparam logic [1:0] AMODE_DEC = 2'h2;
    // A block count of zero stands for sixteen units.
    localparam logic [4:0] BLK_ZERO_UNITS = 5'h10;
    // Engine states.
    typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE, S_FLY} fcdma_state_t;
endpackage : fcdma_pkg

// ---- hdl/fcdma_top.sv ----
// Five-channel DMA controller: register file on AHB-Lite, arbiter, transfer engine and data FIFO.
// Assumes one memory port that takes one unit per handshake and asserts mem_ready when done.
//
// Notes on behaviour
// - Five channels, fixed priority, channel 0 highest.
// - Option swaps priority of channels 0 and 1.
// - Channels 0-2 take external request, edge or level.
// - Channels 0-2 drive request acknowledge outputs.
// - Channels 0-2 drive end-of-transfer outputs.
// - Peripheral interrupt request can start any channel.
// - Software register write can start any channel.
// - Demand, burst, step and block transfer modes.
// - Addresses step up, down or stay, 0-255.
// - Unit size byte, halfword or word.
// - Single-shot stops; reload restores and continues.
// - Source and destination address with reload copies.
// - Sixteen-bit transfer count with reload copy.
// - Four-bit block count sets units per block.
// - Fly-by on channel 3; two-cycle on all.
`timescale 1ns/1ps

// Small synchronous FIFO with valid/ready on both sides.
module fcdma_fifo #(parameter int WIDTH = 32, parameter int DEPTH = 4) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // Pointers carry one extra bit so that full and empty differ.
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fcdma_fifo_state_t;
    fcdma_fifo_state_t r, next_r;
    logic full, empty;
    // Full when the pointers differ only in the wrap bit.
    assign full = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
    assign empty = (r.wp == r.rp);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = r.mem[r.rp[AW-1:0]];
    // Push and pop may happen in the same cycle.
    always_comb
    begin
        next_r = r;
        if (in_valid && !full)
        begin
            next_r.mem[r.wp[AW-1:0]] = in_data;
            next_r.wp = r.wp + 1'b1;
        end
        if (out_ready && !empty)
            next_r.rp = r.rp + 1'b1;
    end
    // State register.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            r <= '0;
        else
            r <= next_r;
    end
endmodule : fcdma_fifo
// Top level of the controller.
module fcdma_top #(parameter int FIFO_DEPTH = 4) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite register slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // External request pins, asynchronous to hclk.
    input wire logic ext_xfer_request_0,
    input wire logic ext_xfer_request_1,
    input wire logic ext_xfer_request_2,
    // Acknowledge and end-of-transfer pins.
    output logic request_accept_out_0,
    output logic request_accept_out_1,
    output logic request_accept_out_2,
    output logic transfer_end_out_0,
    output logic transfer_end_out_1,
    output logic transfer_end_out_2,
    // Internal peripheral requests, one per channel, on hclk.
    input wire logic [4:0] periph_req,
    // Memory port, one unit per handshake.
    output logic mem_req,
    output logic mem_write,
    output logic [31:0] mem_addr,
    output logic [1:0] mem_size,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ready,
    // Fly-by strobe towards the I/O device and its direction (1 = memory to I/O).
    output logic flyby_io_strobe,
    output logic flyby_to_io
);
    // Whole controller state in one record.
    typedef struct packed {
        logic [4:0][15:0] cnt, cnt_rl;
        logic [4:0][3:0] blk;
        logic [4:0][4:0] blk_left;
        logic [4:0][31:0] src, src_rl, dst, dst_rl;
        logic [4:0][1:0] trig, mode, size, smode, dmode;
        logic [4:0][7:0] sstep, dstep;
        logic [4:0] edge_mode, enable, reload, sw_pend, done, active;
        logic fly_en, fly_dir, bus_act, bus_wr;
        logic [2:0] ext_s1, ext_s2, ext_s3, ext_pend, eop, gctrl, cur;
        fcdma_pkg::fcdma_state_t state;
        logic [7:0] bus_addr;
    } fcdma_state_rec_t;
    fcdma_state_rec_t r, next_r;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready, unit_done;
    logic [31:0] fifo_out_data;
    logic [4:0] req, elig, done_set;
    logic [3:0] pick;
    logic [2:0] c, wch;
    logic [31:0] w;
    // Highest eligible channel; bit 3 flags a winner, with optional 0/1 swap.
    function automatic logic [3:0] arbitrate(input logic [4:0] e, input logic swap);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 4; i >= 0; i--)
            if (e[i])
                res = {1'b1, 3'(i)};
        if (swap && e[1])
            res = 4'h9;
        return res;
    endfunction : arbitrate
    // Next address after one unit: step up, step down or hold.
    function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [7:0] s, input logic [1:0] m);
        logic [31:0] res;
        res = a;
        if (m == fcdma_pkg::AMODE_INC)
            res = a + {24'h00_0000, s};
        else if (m == fcdma_pkg::AMODE_DEC)
            res = a - {24'h00_0000, s};
        return res;
    endfunction : step_addr
    // Units in one block for a given block count.
    function automatic logic [4:0] block_units(input logic [3:0] b);
        return (b == 4'h0) ? fcdma_pkg::BLK_ZERO_UNITS : {1'b0, b};
    endfunction : block_units
    // The FIFO holds read data until the write half of the unit drains it.
    fcdma_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .hclk(hclk), .hresetn(hresetn),
        .in_valid(fifo_in_valid), .in_ready(fifo_in_ready), .in_data(mem_rdata),
        .out_valid(fifo_out_valid), .out_ready(fifo_out_ready), .out_data(fifo_out_data)
    );
    // Request per channel from its selected source.
    always_comb
    begin
        for (int i = 0; i < fcdma_pkg::NUM_CH; i++)
        begin
            case (r.trig[i])
                fcdma_pkg::TRIG_SW: req[i] = r.sw_pend[i];
                fcdma_pkg::TRIG_EXT: req[i] = (i < fcdma_pkg::NUM_EXT) &&
                    (r.edge_mode[i] ? r.ext_pend[i % 3] : r.ext_s2[i % 3]);
                fcdma_pkg::TRIG_PERIPH: req[i] = periph_req[i];
                default: req[i] = 1'b0;
            endcase
        end
        elig = r.enable & (r.active | req) & {5{r.gctrl[fcdma_pkg::G_ENABLE]}};
        pick = arbitrate(elig, r.gctrl[fcdma_pkg::G_SWAP01]);
    end
    // Memory port and FIFO handshakes follow the engine state; reads wait while the FIFO is full.
    assign c = r.cur;
    assign mem_req = (r.state == fcdma_pkg::S_READ) ? fifo_in_ready :
                     (r.state == fcdma_pkg::S_WRITE) ? fifo_out_valid : (r.state == fcdma_pkg::S_FLY);
    assign mem_write = (r.state == fcdma_pkg::S_WRITE) || ((r.state == fcdma_pkg::S_FLY) && !r.fly_dir);
    assign mem_addr = ((r.state == fcdma_pkg::S_READ) || ((r.state == fcdma_pkg::S_FLY) && r.fly_dir)) ?
                      r.src[c] : r.dst[c];
    assign mem_size = r.size[c];
    assign mem_wdata = fifo_out_data;
    assign fifo_in_valid = (r.state == fcdma_pkg::S_READ) && mem_ready;
    assign fifo_out_ready = (r.state == fcdma_pkg::S_WRITE) && mem_ready;
    assign flyby_io_strobe = (r.state == fcdma_pkg::S_FLY);
    assign flyby_to_io = r.fly_dir;
    // Acknowledge while an externally triggered channel owns the bus.
    assign request_accept_out_0 = (r.state != fcdma_pkg::S_IDLE) && (c == 3'h0) && (r.trig[0] == fcdma_pkg::TRIG_EXT);
    assign request_accept_out_1 = (r.state != fcdma_pkg::S_IDLE) && (c == 3'h1) && (r.trig[1] == fcdma_pkg::TRIG_EXT);
    assign request_accept_out_2 = (r.state != fcdma_pkg::S_IDLE) && (c == 3'h2) && (r.trig[2] == fcdma_pkg::TRIG_EXT);
    assign transfer_end_out_0 = r.eop[0];
    assign transfer_end_out_1 = r.eop[1];
    assign transfer_end_out_2 = r.eop[2];
    // The slave never stalls and always answers OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // Read data for the data phase; unmapped addresses read as zero.
    always_comb
    begin
        hrdata = 32'h0000_0000;
        wch = r.bus_addr[6:4];
        if (r.bus_act && !r.bus_wr)
        begin
            if (r.bus_addr == fcdma_pkg::ADDR_GLOBAL)
                hrdata = {29'h0000_0000, r.gctrl};
            else if ((wch < 3'h5) && !r.bus_addr[7])
            begin
                case (r.bus_addr[3:2])
                    fcdma_pkg::REG_CTRL_A: hrdata = {2'h0, r.size[wch], r.mode[wch], r.reload[wch], r.enable[wch],
                        r.sw_pend[wch], r.edge_mode[wch], r.trig[wch], r.blk[wch], r.cnt[wch]};
                    fcdma_pkg::REG_CTRL_B: hrdata = {(r.state != fcdma_pkg::S_IDLE) && (c == wch), r.done[wch], 8'h00,
                        (wch == fcdma_pkg::FLY_CH) && r.fly_en, (wch == fcdma_pkg::FLY_CH) && r.fly_dir,
                        r.dmode[wch], r.dstep[wch], r.smode[wch], r.sstep[wch]};
                    fcdma_pkg::REG_SRC: hrdata = r.src[wch];
                    fcdma_pkg::REG_DST: hrdata = r.dst[wch];
                    default: hrdata = 32'h0000_0000;
                endcase
            end
        end
    end
    // Engine, synchronisers and register writes.
    always_comb
    begin
        next_r = r;
        unit_done = 1'b0;
        done_set = 5'h00;
        w = hwdata;
        next_r.eop = 3'h0;
        // Pins pass two flops before use; the third flop only feeds edge detection.
        next_r.ext_s1 = {ext_xfer_request_2, ext_xfer_request_1, ext_xfer_request_0};
        next_r.ext_s2 = r.ext_s1;
        next_r.ext_s3 = r.ext_s2;
        case (r.state)
            fcdma_pkg::S_IDLE:
            begin
                // A new owner is chosen only between units.
                if (pick[3] && !r.gctrl[fcdma_pkg::G_HALT])
                begin
                    next_r.cur = pick[2:0];
                    if (!r.active[pick[2:0]])
                    begin
                        next_r.sw_pend[pick[2:0]] = 1'b0;
                        if (pick[2:0] < 3'h3)
                            next_r.ext_pend[pick[1:0]] = 1'b0;
                        if ((r.mode[pick[2:0]] == fcdma_pkg::MODE_BURST) ||
                            (r.mode[pick[2:0]] == fcdma_pkg::MODE_BLOCK))
                            next_r.active[pick[2:0]] = 1'b1;
                    end
                    next_r.state = ((pick[2:0] == fcdma_pkg::FLY_CH) && r.fly_en) ?
                                   fcdma_pkg::S_FLY : fcdma_pkg::S_READ;
                end
            end
            fcdma_pkg::S_READ: next_r.state = (fifo_in_ready && mem_ready) ? fcdma_pkg::S_WRITE : fcdma_pkg::S_READ;
            fcdma_pkg::S_WRITE: unit_done = fifo_out_valid && mem_ready;
            fcdma_pkg::S_FLY: unit_done = mem_ready;
            default: next_r.state = fcdma_pkg::S_IDLE;
        endcase
        // A fresh edge is set after the grant clear, so one landing in the grant cycle is kept.
        for (int i = 0; i < fcdma_pkg::NUM_EXT; i++)
            if (r.edge_mode[i] && r.ext_s2[i] && !r.ext_s3[i]) next_r.ext_pend[i] = 1'b1;
        // Bookkeeping once a whole unit has moved.
        if (unit_done)
        begin
            next_r.state = fcdma_pkg::S_IDLE;
            next_r.src[c] = step_addr(r.src[c], r.sstep[c], r.smode[c]);
            next_r.dst[c] = step_addr(r.dst[c], r.dstep[c], r.dmode[c]);
            next_r.blk_left[c] = r.blk_left[c] - 5'h01;
            if ((r.mode[c] == fcdma_pkg::MODE_STEP) || (r.mode[c] == fcdma_pkg::MODE_DEMAND))
                next_r.active[c] = 1'b0;
            if (r.blk_left[c] <= 5'h01)
            begin
                next_r.blk_left[c] = block_units(r.blk[c]);
                next_r.cnt[c] = r.cnt[c] - 16'h0001;
                if (r.mode[c] == fcdma_pkg::MODE_BLOCK)
                    next_r.active[c] = 1'b0;
                if (r.cnt[c] <= 16'h0001)
                begin
                    done_set[c] = 1'b1;
                    next_r.done[c] = 1'b1;
                    next_r.active[c] = 1'b0;
                    if (c < 3'h3)
                        next_r.eop[c[1:0]] = 1'b1;
                    if (r.reload[c])
                    begin
                        next_r.cnt[c] = r.cnt_rl[c];
                        next_r.src[c] = r.src_rl[c];
                        next_r.dst[c] = r.dst_rl[c];
                    end
                    else
                        next_r.enable[c] = 1'b0;
                end
            end
        end
        // Address phase capture for the next data phase.
        next_r.bus_act = hsel && htrans[1] && hready;
        next_r.bus_wr = hwrite;
        next_r.bus_addr = haddr[7:0];
        // Data phase write; it follows the engine so software settings win, except the done flag.
        if (r.bus_act && r.bus_wr)
        begin
            if (r.bus_addr == fcdma_pkg::ADDR_GLOBAL)
                next_r.gctrl = w[2:0];
            else if ((wch < 3'h5) && !r.bus_addr[7])
            begin
                case (r.bus_addr[3:2])
                    fcdma_pkg::REG_CTRL_A:
                    begin
                        next_r.cnt[wch] = w[fcdma_pkg::A_CNT_LSB +: 16];
                        next_r.cnt_rl[wch] = w[fcdma_pkg::A_CNT_LSB +: 16];
                        next_r.blk[wch] = w[fcdma_pkg::A_BLK_LSB +: 4];
                        next_r.blk_left[wch] = block_units(w[fcdma_pkg::A_BLK_LSB +: 4]);
                        next_r.trig[wch] = w[fcdma_pkg::A_TRIG_LSB +: 2];
                        next_r.edge_mode[wch] = w[fcdma_pkg::A_EDGE];
                        next_r.sw_pend[wch] = r.sw_pend[wch] | w[fcdma_pkg::A_SWREQ];
                        next_r.enable[wch] = w[fcdma_pkg::A_ENABLE];
                        next_r.reload[wch] = w[fcdma_pkg::A_RELOAD];
                        next_r.mode[wch] = w[fcdma_pkg::A_MODE_LSB +: 2];
                        next_r.size[wch] = w[fcdma_pkg::A_SIZE_LSB +: 2];
                        next_r.active[wch] = 1'b0;
                    end
                    fcdma_pkg::REG_CTRL_B:
                    begin
                        next_r.sstep[wch] = w[fcdma_pkg::B_SSTEP_LSB +: 8];
                        next_r.smode[wch] = w[fcdma_pkg::B_SMODE_LSB +: 2];
                        next_r.dstep[wch] = w[fcdma_pkg::B_DSTEP_LSB +: 8];
                        next_r.dmode[wch] = w[fcdma_pkg::B_DMODE_LSB +: 2];
                        if (wch == fcdma_pkg::FLY_CH)
                        begin
                            next_r.fly_dir = w[fcdma_pkg::B_FLY_DIR];
                            next_r.fly_en = w[fcdma_pkg::B_FLY_EN];
                        end
                        // Writing one clears the flag, but a completion in the same cycle wins.
                        if (w[fcdma_pkg::B_DONE] && !done_set[wch])
                            next_r.done[wch] = 1'b0;
                    end
                    fcdma_pkg::REG_SRC:
                    begin
                        next_r.src[wch] = w;
                        next_r.src_rl[wch] = w;
                    end
                    fcdma_pkg::REG_DST:
                    begin
                        next_r.dst[wch] = w;
                        next_r.dst_rl[wch] = w;
                    end
                    default: next_r.done = next_r.done;
                endcase
            end
        end
    end
    // State register; every field resets to zero.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            r <= '0;
        else
            r <= next_r;
    end
endmodule : fcdma_top

// ---- tb/fcdma_mem_model.sv ----
// Memory model at the far side of the controller's transfer port.
// Assumes the bench feeds a random go bit so that some answers are slow.
`timescale 1ns/1ps
module fcdma_mem_model (
    // Transfer port.
    input wire logic hclk,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic go,
    output logic mem_ready,
    output logic [31:0] mem_rdata
);
    logic tog = 1'b0; // Flips each cycle, so idle read data never repeats the last word.
    always @(posedge hclk) tog <= ~tog;
    // Answer only while asked; the data word is derived from the address.
    assign mem_ready = mem_req & go;
    assign mem_rdata = (mem_req & ~mem_write) ? {~mem_addr[15:0], mem_addr[15:0]} : {32{tog}};
endmodule : fcdma_mem_model

// ---- tb/fcdma_top_props.sv ----
// Checker of the controller's top-level ports.
// Assumes it is bound into every instance of the top module.
`timescale 1ns/1ps
module fcdma_top_props (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Bus answer and channel pins.
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic request_accept_out_0,
    input wire logic request_accept_out_1,
    input wire logic request_accept_out_2,
    input wire logic transfer_end_out_0,
    input wire logic transfer_end_out_1,
    input wire logic transfer_end_out_2,
    // Memory port.
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ready,
    input wire logic flyby_io_strobe,
    input wire logic flyby_to_io
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Completion of the read half and of the write half of a two-cycle unit.
    sequence rd_done; mem_req && mem_ready && !mem_write && !flyby_io_strobe; endsequence
    sequence wr_done; mem_req && mem_ready && mem_write && !flyby_io_strobe; endsequence
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("register bus answer not zero-wait OKAY");
    one_owner_a: assert property ($onehot0({request_accept_out_0, request_accept_out_1, request_accept_out_2}))
        else $error("two channels accepted at once");
    req_hold_a: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr) && $stable(mem_write))
        else $error("memory access changed before its answer");
    read_write_a: assert property (rd_done |=> mem_req && mem_write && mem_wdata == $past(mem_rdata))
        else $error("write half did not follow the read half");
    unit_gap_a: assert property (wr_done |=> !mem_req)
        else $error("no arbitration gap after a unit");
    eop_pulse_a: assert property (transfer_end_out_0 |-> $past(mem_req && mem_ready) ##1 !transfer_end_out_0)
        else $error("end pulse on channel 0 malformed");
    eop_idle_a: assert property (transfer_end_out_1 || transfer_end_out_2 |-> !mem_req && $past(mem_ready))
        else $error("end pulse not after a finished unit");
    fly_dir_a: assert property (flyby_io_strobe |-> mem_req && (mem_write == !flyby_to_io))
        else $error("fly-by access direction wrong");
endmodule : fcdma_top_props
bind fcdma_top fcdma_top_props u_props (.*);

// ---- tb/five_channel_dma_controller_bench.sv ----
// Self-checking bench: registers, all modes, priority, pin and peripheral triggers.
// Assumes the memory model answers with random stalls from the bench's shift register.
`timescale 1ns/1ps
module five_channel_dma_controller_bench;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, go = 1'b0, hreadyout, hresp, mem_req, mem_write, mem_ready;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, mem_addr, mem_wdata, mem_rdata, rd;
    logic [31:0] lfsr = 32'h0001_6E21; // Fixed seed keeps runs repeatable.
    logic [1:0] htrans = '0, mem_size;
    logic [4:0] periph_req = '0;
    logic [2:0] ext = '0, acc, eop;
    logic fly_s, fly_d;
    int err_total = 0, cmp_count = 0;
    logic [31:0] wq[$], dq[$]; // Address and data of each finished write.
    always #50 hclk = ~hclk;
    fcdma_top uut (.*, .hsel(1'b1), .hsize(3'h2), .hready(hreadyout),
        .ext_xfer_request_0(ext[0]), .ext_xfer_request_1(ext[1]), .ext_xfer_request_2(ext[2]),
        .request_accept_out_0(acc[0]), .request_accept_out_1(acc[1]), .request_accept_out_2(acc[2]),
        .transfer_end_out_0(eop[0]), .transfer_end_out_1(eop[1]), .transfer_end_out_2(eop[2]),
        .flyby_io_strobe(fly_s), .flyby_to_io(fly_d));
    fcdma_mem_model mem (.*);
    // Random stalls on the memory side; the register also feeds random addresses.
    always @(posedge hclk)
    begin
        lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        go <= lfsr[3] | lfsr[7];
        if (mem_req && mem_ready)
            chk("unit size", 32'(mem_size), 32'h0000_0002);
        if (mem_req && mem_ready && mem_write)
        begin
            wq.push_back(mem_addr);
            dq.push_back(mem_wdata);
        end
    end
    function automatic logic [31:0] mv(input logic [31:0] a);
        return {~a[15:0], a[15:0]};
    endfunction : mv
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // Samples mid-cycle; a wait that runs out ends the run as a failure.
    task automatic settle(inout int n);
        @(negedge hclk);
        n++;
        if (n > 3000)
        begin
            err_total++;
            close_out();
        end
    endtask : settle
    task automatic phase(inout int n);
        logic r;
        do
        begin
            settle(n);
            r = hreadyout;
            rd = hrdata;
            @(posedge hclk);
        end while (!r);
    endtask : phase
    // One single word transfer: address phase, then data phase.
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n = 0;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        phase(n);
        htrans <= 2'h0;
        hwdata <= d;
        phase(n);
    endtask : ahb
    // Word units, one unit a block, addresses rising by four; channel 3 goes fly-by.
    task automatic setup(input int c, input logic [1:0] t, input logic [1:0] md, input logic [15:0] cnt,
        input logic [31:0] s, input logic [31:0] d);
        ahb(1'b1, 32'(c * 16 + 8), s);
        ahb(1'b1, 32'(c * 16 + 12), d);
        ahb(1'b1, 32'(c * 16 + 4), 32'h4004_1104 | (c == 3 ? 32'h0030_0000 : 32'h0000_0000));
        ahb(1'b1, 32'(c * 16), {2'h0, 2'h2, md, 1'b0, 1'b1, t == 2'h0, t == 2'h1, t, 4'h1, cnt});
    endtask : setup
    task automatic wait_done(input int c);
        int n = 0;
        do
        begin
            ahb(1'b0, 32'(c * 16 + 4), 32'h0000_0000);
            n++;
        end while (!rd[30] && n < 300);
        chk("done flag", 32'(rd[30]), 32'h0000_0001);
        ahb(1'b0, 32'(c * 16), 32'h0000_0000);
        chk("count and enable", rd & 32'h0100_FFFF, 32'h0000_0000);
    endtask : wait_done
    initial
    begin
        logic [31:0] s;
        int n;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 32'h0000_0060, 32'h0000_0000);
        chk("unmapped", rd, 32'h0000_0000);
        for (int c = 0; c < 5; c++)
        begin
            s = lfsr;
            ahb(1'b0, 32'(c * 16 + 8), 32'h0000_0000);
            chk("source reset", rd, 32'h0000_0000);
            ahb(1'b1, 32'(c * 16 + 12), s);
            ahb(1'b0, 32'(c * 16 + 12), 32'h0000_0000);
            chk("dest readback", rd, s);
        end
        ahb(1'b1, 32'h0000_0050, 32'h0000_0001);
        // Every mode once on channel 4; burst moves the whole count per request.
        for (int m = 0; m < 4; m++)
        begin
            s = lfsr & 32'h00FF_FFF0;
            wq.delete();
            dq.delete();
            setup(4, 2'h0, m[1:0], m == 1 ? 16'h0003 : 16'h0001, s, s ^ 32'h0100_0000);
            wait_done(4);
            chk("units", 32'(wq.size()), m == 1 ? 32'h0000_0003 : 32'h0000_0001);
            foreach (wq[k])
            begin
                chk("dest addr", wq[k], (s ^ 32'h0100_0000) + 4 * k);
                chk("data", dq[k], mv(s + 4 * k));
            end
        end
        // Channels 0 and 1 asked together, with and without the swap.
        for (int sw = 0; sw < 2; sw++)
        begin
            ahb(1'b1, 32'h0000_0050, 32'h0000_0000);
            wq.delete();
            setup(0, 2'h0, 2'h2, 16'h0001, 32'h0000_0100, 32'h0000_2000);
            setup(1, 2'h0, 2'h2, 16'h0001, 32'h0000_0200, 32'h0000_3000);
            ahb(1'b1, 32'h0000_0050, {30'h0, sw[0], 1'b1});
            wait_done(0);
            wait_done(1);
            chk("first owner", wq[0], sw == 1 ? 32'h0000_3000 : 32'h0000_2000);
        end
        setup(2, 2'h1, 2'h3, 16'h0001, 32'h0000_0500, 32'h0000_4000);
        ext[2] <= 1'b1;
        n = 0;
        while (!acc[2]) settle(n);
        chk("accept pins", 32'(acc), 32'h0000_0004);
        @(posedge hclk);
        ext[2] <= 1'b0;
        while (!eop[2]) settle(n);
        chk("end pins", 32'(eop), 32'h0000_0004);
        @(posedge hclk);
        wait_done(2);
        periph_req[3] <= 1'b1;
        setup(3, 2'h2, 2'h0, 16'h0001, 32'h0000_0600, 32'h0000_5000);
        wait_done(3);
        periph_req[3] <= 1'b0;
        close_out();
    end
endmodule : five_channel_dma_controller_bench
